// ===== rtl/adc_scan_pkg.sv
package adc_scan_pkg;

   // Register byte offsets
   localparam logic [3:0] ref_cfg_offset = 4'h0;
   localparam logic [3:0] scan_low_offset = 4'h4;
   localparam logic [3:0] scan_high_offset = 4'h8;

   // Register widths and implemented masks
   localparam int reg_width = 16;
   localparam logic [15:0] ref_cfg_mask = 16'h0007;
   localparam logic [15:0] scan_low_mask = 16'hffff;
   localparam logic [15:0] scan_high_mask = 16'h0fff;
   localparam logic [15:0] reg_reset = 16'h0000;

   // Reference enable bit positions
   localparam int full_ref_bit = 0;
   localparam int half_ref_bit = 1;
   localparam int sixth_ref_bit = 2;

   // AXI response codes
   localparam logic [1:0] resp_okay = 2'h0;
   localparam logic [1:0] resp_slverr = 2'h2;

endpackage : adc_scan_pkg

// ===== rtl/adc_scan_and_refsel.sv
// Implementation choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

// Function
// - Bit 2 of reference config turns the one-sixth band gap on or off
// - Bit 1 of reference config turns the half band gap on or off
// - Bit 0 of reference config turns the full band gap on or off
// - Reference config bits 15..3 are unimplemented, read zero, ignore writes
// - Each low scan-select bit includes matching channel 0..15 in scan
module adc_scan_and_refsel
   import adc_scan_pkg::*;
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Converter controls
   output logic full_ref_on,
   output logic half_ref_on,
   output logic sixth_ref_on,
   output logic [27:0] scan_include_bits
);

   ////////////////////////////////////////////////////////////////////////
   // Register selection decoded from a bus address
   typedef enum logic [1:0] {
      sel_ref_cfg = 2'b00,
      sel_scan_low = 2'b01,
      sel_scan_high = 2'b10,
      sel_none = 2'b11
   } reg_sel_type;

   ////////////////////////////////////////////////////////////////////////
   // State
   typedef struct packed {
      // Write address channel
      logic awready;
      logic aw_held;
      logic [3:0] aw_addr;

      // Write data channel
      logic wready;
      logic w_held;
      logic [31:0] w_data;
      logic [3:0] w_strb;

      // Write response channel
      logic bvalid;
      logic [1:0] bresp;

      // Read address and data channels
      logic arready;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;

      // Software-visible registers
      logic [reg_width-1:0] ref_cfg;
      logic [reg_width-1:0] scan_low;
      logic [reg_width-1:0] scan_high;
   } state_type;

   // Current and next state
   state_type state_reg;
   state_type state_next;

   ////////////////////////////////////////////////////////////////////////
   // Functions

   // Byte-lane merge limited to implemented bits
   function automatic logic [reg_width-1:0] merge(
         input logic [reg_width-1:0] old,
         input logic [31:0] data,
         input logic [3:0] strb,
         input logic [reg_width-1:0] mask);
      logic [reg_width-1:0] v;
      v = old;

      // Lanes 2 and 3 carry no register bits and are dropped
      if (strb[0]) begin
         v[7:0] = data[7:0];
      end
      if (strb[1]) begin
         v[15:8] = data[15:8];
      end
      // Unimplemented bits never latch a one
      return v & mask;
   endfunction : merge

   // Address decode shared by the write and read paths
   function automatic reg_sel_type decode(input logic [3:0] a);
      reg_sel_type s;
      unique case (a)
         ref_cfg_offset: begin
            s = sel_ref_cfg;
         end
         scan_low_offset: begin
            s = sel_scan_low;
         end
         scan_high_offset: begin
            s = sel_scan_high;
         end
         default: begin
            s = sel_none;
         end
      endcase
      return s;
   endfunction : decode

   // Response code: unmapped offsets answer with a slave error
   function automatic logic [1:0] resp_of(input reg_sel_type s);
      logic [1:0] r;
      r = resp_okay;
      if (s == sel_none) begin
         r = resp_slverr;
      end
      return r;
   endfunction : resp_of

   // Read value of a register, unimplemented bits as zero
   function automatic logic [31:0] read_word(input reg_sel_type s,
         input state_type st);
      logic [31:0] w;
      w = '0;

      unique case (s)
         sel_ref_cfg: begin
            w[reg_width-1:0] = st.ref_cfg & ref_cfg_mask;
         end
         sel_scan_low: begin
            w[reg_width-1:0] = st.scan_low & scan_low_mask;
         end
         sel_scan_high: begin
            w[reg_width-1:0] = st.scan_high & scan_high_mask;
         end
         sel_none: begin
            w = '0;
         end
      endcase
      return w;
   endfunction : read_word

   ////////////////////////////////////////////////////////////////////////
   // Next-state logic
   always_comb begin
      reg_sel_type wr_sel;
      reg_sel_type rd_sel;
      logic write_go;
      logic read_go;

      // Decode and qualify before anything else
      wr_sel = decode(state_reg.aw_addr);
      rd_sel = decode(s_axi_araddr);
      write_go = state_reg.aw_held && state_reg.w_held && !state_reg.bvalid;
      read_go = s_axi_arvalid && state_reg.arready;
      state_next = state_reg;

      // Write address taken while no address is held
      if (s_axi_awvalid && state_reg.awready) begin
         state_next.aw_held = 1'b1;
         state_next.aw_addr = s_axi_awaddr;
      end

      // Write data taken while no data is held, in either order
      if (s_axi_wvalid && state_reg.wready) begin
         state_next.w_held = 1'b1;
         state_next.w_data = s_axi_wdata;
         state_next.w_strb = s_axi_wstrb;
      end

      // Write response leaves once the master has taken it
      if (state_reg.bvalid && s_axi_bready) begin
         state_next.bvalid = 1'b0;
      end

      // Register update once both halves are held and no response waits;
      // a pending response holds the write back so none is lost
      if (write_go) begin
         state_next.aw_held = 1'b0;
         state_next.w_held = 1'b0;
         state_next.bvalid = 1'b1;
         state_next.bresp = resp_of(wr_sel);
         unique case (wr_sel)
            sel_ref_cfg: begin
               state_next.ref_cfg = merge(state_reg.ref_cfg,
                  state_reg.w_data, state_reg.w_strb,
                  ref_cfg_mask);
            end
            sel_scan_low: begin
               state_next.scan_low = merge(state_reg.scan_low,
                  state_reg.w_data, state_reg.w_strb,
                  scan_low_mask);
            end
            sel_scan_high: begin
               state_next.scan_high = merge(state_reg.scan_high,
                  state_reg.w_data, state_reg.w_strb,
                  scan_high_mask);
            end
            sel_none: begin
               // Unmapped offset: registers keep their values
               state_next.ref_cfg = state_reg.ref_cfg;
            end
         endcase
      end

      // Read data leaves once the master has taken it
      if (state_reg.rvalid && s_axi_rready) begin
         state_next.rvalid = 1'b0;
      end

      // Read taken while no read data is pending; a write landing on
      // the same edge is not yet visible, so the old value is returned
      if (read_go) begin
         state_next.rvalid = 1'b1;
         state_next.rresp = resp_of(rd_sel);
         state_next.rdata = read_word(rd_sel, state_reg);
      end

      // Ready flags kept in flip-flops so the bus sees no gate delay
      state_next.awready = !state_next.aw_held;
      state_next.wready = !state_next.w_held;
      state_next.arready = !state_next.rvalid;

      // Synchronous reset: registers clear, all channels idle and ready
      if (!aresetn) begin
         // Write address channel free
         state_next.awready = 1'b1;
         state_next.aw_held = 1'b0;
         state_next.aw_addr = '0;

         // Write data channel free
         state_next.wready = 1'b1;
         state_next.w_held = 1'b0;
         state_next.w_data = '0;
         state_next.w_strb = '0;

         // No write response pending
         state_next.bvalid = 1'b0;
         state_next.bresp = resp_okay;

         // Read channels free
         state_next.arready = 1'b1;
         state_next.rvalid = 1'b0;
         state_next.rresp = resp_okay;
         state_next.rdata = '0;

         // Software-visible registers at their reset value
         state_next.ref_cfg = reg_reset;
         state_next.scan_low = reg_reset;
         state_next.scan_high = reg_reset;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge aclk) begin
      state_reg <= state_next;
   end

   ////////////////////////////////////////////////////////////////////////
   // Bus handshake readies straight from flip-flops
   assign s_axi_awready = state_reg.awready;
   assign s_axi_wready = state_reg.wready;
   assign s_axi_arready = state_reg.arready;

   // Write response straight from flip-flops
   assign s_axi_bvalid = state_reg.bvalid;
   assign s_axi_bresp = state_reg.bresp;

   // Read response straight from flip-flops
   assign s_axi_rvalid = state_reg.rvalid;
   assign s_axi_rresp = state_reg.rresp;
   assign s_axi_rdata = state_reg.rdata;

   // Reference enables straight from the configuration flip-flops
   assign full_ref_on = state_reg.ref_cfg[full_ref_bit];
   assign half_ref_on = state_reg.ref_cfg[half_ref_bit];
   assign sixth_ref_on = state_reg.ref_cfg[sixth_ref_bit];

   // Channels 0..15, then 16..23, half, full, core, sixth
   assign scan_include_bits = {
      state_reg.scan_high[$bits(scan_include_bits)-reg_width-1:0],
      state_reg.scan_low};

endmodule : adc_scan_and_refsel

`default_nettype wire

// ===== test/adc_scan_properties.sv
`timescale 1ns/1ps
`default_nettype none
module adc_scan_checker
   import adc_scan_pkg::*;
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Bus
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_bvalid,
   // Controls
   input wire logic full_ref_on,
   input wire logic half_ref_on,
   input wire logic sixth_ref_on,
   input wire logic [27:0] scan_include_bits
);
   logic [3:0] ra_reg;
   // Address of the read in flight
   always_ff @(posedge aclk)
      if (s_axi_arvalid && s_axi_arready) ra_reg <= s_axi_araddr;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Controls move only with a write response
   sixth_ref_a: assert property ($changed(sixth_ref_on) |->
      $rose(s_axi_bvalid)) else $error("sixth moved");
   half_ref_a: assert property ($changed(half_ref_on) |->
      $rose(s_axi_bvalid)) else $error("half moved");
   full_ref_a: assert property ($changed(full_ref_on) |->
      $rose(s_axi_bvalid)) else $error("full moved");
   scan_move_a: assert property ($changed(scan_include_bits) |->
      $rose(s_axi_bvalid)) else $error("scan moved");
   // Read data mirrors the controls
   ref_read_a: assert property ($rose(s_axi_rvalid) &&
      ra_reg == ref_cfg_offset |-> s_axi_rdata == {29'h0,
      $past(sixth_ref_on), $past(half_ref_on), $past(full_ref_on)})
      else $error("ref read");
   low_read_a: assert property ($rose(s_axi_rvalid) &&
      ra_reg == scan_low_offset |->
      s_axi_rdata == {16'h0, $past(scan_include_bits[15:0])})
      else $error("low read");
   high_read_a: assert property ($rose(s_axi_rvalid) &&
      ra_reg == scan_high_offset |->
      s_axi_rdata == {20'h0, $past(scan_include_bits[27:16])})
      else $error("high read");
endmodule : adc_scan_checker
bind adc_scan_and_refsel adc_scan_checker adc_scan_checker_i (.aclk,
   .aresetn, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
   .s_axi_rvalid, .s_axi_bvalid, .full_ref_on, .half_ref_on, .sixth_ref_on,
   .scan_include_bits);
`default_nettype wire

// ===== test/test_adc_scan_and_refsel.sv
`timescale 1ns/1ps
`default_nettype none
module test_adc_scan_and_refsel import adc_scan_pkg::*;;
   logic aclk = 1'h0, aresetn = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
   logic s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic [3:0] s_axi_awaddr = 4'h0, s_axi_wstrb = 4'h0, s_axi_araddr = 4'h0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, full_ref_on, half_ref_on, sixth_ref_on;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [27:0] scan_include_bits;
   int n_fail = 0, total_checks = 0;
   adc_scan_and_refsel adc_scan_and_refsel_i (.aclk(aclk),
      .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .full_ref_on(full_ref_on), .half_ref_on(half_ref_on),
      .sixth_ref_on(sixth_ref_on), .scan_include_bits(scan_include_bits));
   always #4 aclk = ~aclk;
   ////////////////////////////////////////////////////////////
   // Compare and count
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         n_fail++;
         $display("ERROR %s exp %h got %h", n, e, g);
      end
   endtask : chk
   // Bus write, both channels at once
   task wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
         input logic [1:0] r);
      logic [2:0] p;
      @(posedge aclk);
      p = 3'h7;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      for (int i = 0; p != 3'h0; i++) begin
         @(posedge aclk);
         if (i > 40) begin
            n_fail++;
            $display("ERROR write wait exp %0d got %0d", 40, i);
            conclude();
         end
         if (p[0] && s_axi_awready) s_axi_awvalid <= 1'h0;
         if (p[0] && s_axi_awready) p[0] = 1'h0;
         if (p[1] && s_axi_wready) s_axi_wvalid <= 1'h0;
         if (p[1] && s_axi_wready) p[1] = 1'h0;
         if (p[2] && s_axi_bvalid) begin
            s_axi_bready <= 1'h0;
            chk("bresp", r, s_axi_bresp);
            p[2] = 1'h0;
         end
      end
   endtask : wr
   // Bus read with data and response check
   task rd(input logic [3:0] a, input logic [31:0] e, input logic [1:0] r);
      logic [1:0] p;
      @(posedge aclk);
      p = 2'h3;
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      for (int i = 0; p != 2'h0; i++) begin
         @(posedge aclk);
         if (i > 40) begin
            n_fail++;
            $display("ERROR read wait exp %0d got %0d", 40, i);
            conclude();
         end
         if (p[0] && s_axi_arready) s_axi_arvalid <= 1'h0;
         if (p[0] && s_axi_arready) p[0] = 1'h0;
         if (p[1] && s_axi_rvalid) begin
            s_axi_rready <= 1'h0;
            chk("rdata", e, s_axi_rdata);
            chk("rresp", r, s_axi_rresp);
            p[1] = 1'h0;
         end
      end
   endtask : rd
   // Control outputs as one word
   task ctl(input logic [31:0] e);
      chk("ctl", e, {1'h0, scan_include_bits, sixth_ref_on, half_ref_on,
         full_ref_on});
   endtask : ctl
   task conclude();
      $display("checks %0d fails %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : conclude
   ////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      repeat (5) @(posedge aclk);
      aresetn <= 1'h1;
      rd(ref_cfg_offset, 32'h0, resp_okay);
      rd(scan_low_offset, 32'h0, resp_okay);
      rd(scan_high_offset, 32'h0, resp_okay);
      wr(ref_cfg_offset, 32'hfffffffd, 4'hf, resp_okay);
      rd(ref_cfg_offset, 32'h5, resp_okay);
      ctl(32'h5);
      wr(ref_cfg_offset, 32'h2, 4'hf, resp_okay);
      ctl(32'h2);
      wr(scan_low_offset, 32'hffff, 4'h3, resp_okay);
      ctl(32'h7fffa);
      wr(scan_low_offset, 32'h0, 4'h1, resp_okay);
      rd(scan_low_offset, 32'hff00, resp_okay);
      wr(scan_high_offset, 32'hffffffff, 4'hf, resp_okay);
      rd(scan_high_offset, 32'hfff, resp_okay);
      ctl(32'h7ffff802);
      wr(4'hc, 32'h1, 4'hf, resp_slverr);
      rd(4'hc, 32'h0, resp_slverr);
      rd(ref_cfg_offset, 32'h2, resp_okay);
      // Reset in mid-run clears every control
      @(posedge aclk);
      aresetn <= 1'h0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'h1;
      ctl(32'h0);
      rd(scan_high_offset, 32'h0, resp_okay);
      conclude();
   end
endmodule : test_adc_scan_and_refsel
`default_nettype wire
